// ===== sdc_div_stage.sv
module sdc_div_stage (
    input  wire logic                               clk_sys,
    input  wire logic                               rst,
    input  wire logic                               restart,
    input  wire logic                               en_in,
    input  wire logic [sdc_pkg::RATIO_W-1:0]        ratio,
    output logic                                    en_out,
    output logic [sdc_pkg::STAGE_CNT_W-1:0]         count
);
    logic [sdc_pkg::STAGE_CNT_W-1:0] count_reg;
    logic [sdc_pkg::STAGE_CNT_W-1:0] count_next;
    logic [sdc_pkg::RATIO_W-1:0]     last_w;
    logic                            wrap_w;

    assign last_w = ratio - sdc_pkg::RATIO_W'(1);
    // Wrap also when a ratio change left the count beyond the new end
    assign wrap_w     = ({1'b0, count_reg} >= last_w);
    assign en_out     = en_in & wrap_w & ~restart;
    assign count_next = wrap_w ? '0 : count_reg + sdc_pkg::STAGE_CNT_W'(1);
    assign count      = count_reg;

    always_ff @(posedge clk_sys) begin
        if (rst || restart) begin
            count_reg <= '0;
        end else if (en_in) begin
            count_reg <= count_next;
        end
    end

    property p_stage_wrap;
        @(posedge clk_sys) disable iff (rst)
        (en_in && !restart && wrap_w) |=> (count_reg == '0);
    endproperty
    a_stage_wrap: assert property (p_stage_wrap) else $error("stage did not wrap");

    property p_stage_hold;
        @(posedge clk_sys) disable iff (rst)
        (!en_in && !restart) |=> $stable(count_reg);
    endproperty
    a_stage_hold: assert property (p_stage_hold) else $error("stage moved without enable");
endmodule

// ===== sdc_pkg.sv
package sdc_pkg;
    // Register addresses on the configuration port
    localparam logic [6:0] ADDR_PWR_DIV   = 7'h18;
    localparam logic [6:0] ADDR_BIAS_SYNC = 7'h19;
    localparam logic [6:0] ADDR_PULSE     = 7'h1a;
    localparam logic [6:0] ADDR_PHASE     = 7'h1b;
    localparam logic [6:0] ADDR_TRIGGER   = 7'h1c;
    localparam logic [6:0] ADDR_SOURCE    = 7'h70;

    // Values after reset
    localparam logic [7:0] RST_PWR_DIV   = 8'h2f;
    localparam logic [7:0] RST_BIAS_SYNC = 8'h00;
    localparam logic [7:0] RST_PULSE     = 8'h00;
    localparam logic [7:0] RST_PHASE     = 8'h00;
    localparam logic [7:0] RST_TRIGGER   = 8'h00;
    localparam logic [7:0] RST_SOURCE    = 8'h00;

    // Implemented bits; the rest read as zero
    localparam logic [7:0] MASK_TRIGGER = 8'h03;
    localparam logic [7:0] MASK_SOURCE  = 8'h80;

    // Field positions
    localparam int POS_POWERDOWN = 7;
    localparam int POS_TOP_STAGE = 6;
    localparam int POS_MID_HI    = 4;
    localparam int POS_MID_LO    = 2;
    localparam int POS_LOW_STAGE = 0;

    // Divider chain geometry
    localparam int NUM_STAGES   = 4;
    localparam int STAGE_CNT_W  = 4;
    localparam int RATIO_W      = 5;
    localparam int TOTAL_W      = 13;
    localparam int STABLE_W     = 15;

    // Stage ratios
    localparam logic [4:0] RATIO_TWO    = 5'h02;
    localparam logic [4:0] RATIO_FOUR   = 5'h04;
    localparam logic [4:0] RATIO_LOW_BASE = 5'h02;
    localparam logic [12:0] TOTAL_RST   = 13'h0000;
endpackage

// ===== sdc_sysref_divider.sv
// How it works
// - Power-down bit stops all global reference logic
// - Total ratio is product of four stages
// - Top 2 or 4; middles 2/4/8/16
// - Lowest stage divides by 2, 3, 4, 5
module sdc_sysref_divider (
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic                           reg_wr_en,
    input  wire logic                           reg_rd_en,
    input  wire logic [6:0]                     reg_addr,
    input  wire logic [7:0]                     reg_wdata,
    output logic [7:0]                          reg_rdata,
    output logic                                sysref_out,
    output logic                                sysref_active,
    output logic [sdc_pkg::TOTAL_W-1:0]         sysref_ratio_total,
    output logic [7:0]                          bias_sync_cfg,
    output logic [7:0]                          pulse_cfg,
    output logic [7:0]                          phase_cfg,
    output logic                                generation_trigger_bit,
    output logic                                output_trigger_bit,
    output logic                                source_select_bit
);
    localparam int NS = sdc_pkg::NUM_STAGES;
    localparam int RW = sdc_pkg::RATIO_W;
    localparam int TW = sdc_pkg::TOTAL_W;
    localparam int CW = sdc_pkg::STAGE_CNT_W;

    logic [7:0] pwr_div_reg;
    logic [7:0] bias_sync_reg;
    logic [7:0] pulse_reg;
    logic [7:0] phase_reg;
    logic [7:0] trigger_reg;
    logic [7:0] source_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       sysref_out_reg;
    logic       sysref_out_next;
    logic [TW-1:0] total_reg;
    logic [TW-1:0] total_next;

    // Address decode
    logic sel_pwr_div;
    logic sel_bias;
    logic sel_pulse;
    logic sel_phase;
    logic sel_trigger;
    logic sel_source;
    assign sel_pwr_div = (reg_addr == sdc_pkg::ADDR_PWR_DIV);
    assign sel_bias    = (reg_addr == sdc_pkg::ADDR_BIAS_SYNC);
    assign sel_pulse   = (reg_addr == sdc_pkg::ADDR_PULSE);
    assign sel_phase   = (reg_addr == sdc_pkg::ADDR_PHASE);
    assign sel_trigger = (reg_addr == sdc_pkg::ADDR_TRIGGER);
    assign sel_source  = (reg_addr == sdc_pkg::ADDR_SOURCE);

    // Read mux; unmapped addresses read zero
    assign rdata_next = sel_pwr_div ? pwr_div_reg :
                        sel_bias    ? bias_sync_reg :
                        sel_pulse   ? pulse_reg :
                        sel_phase   ? phase_reg :
                        sel_trigger ? (trigger_reg & sdc_pkg::MASK_TRIGGER) :
                        sel_source  ? (source_reg & sdc_pkg::MASK_SOURCE) :
                        8'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwr_div_reg   <= sdc_pkg::RST_PWR_DIV;
            bias_sync_reg <= sdc_pkg::RST_BIAS_SYNC;
            pulse_reg     <= sdc_pkg::RST_PULSE;
            phase_reg     <= sdc_pkg::RST_PHASE;
            trigger_reg   <= sdc_pkg::RST_TRIGGER;
            source_reg    <= sdc_pkg::RST_SOURCE;
        end else if (reg_wr_en) begin
            if (sel_pwr_div) pwr_div_reg <= reg_wdata;
            if (sel_bias) bias_sync_reg <= reg_wdata;
            if (sel_pulse) pulse_reg <= reg_wdata;
            if (sel_phase) phase_reg <= reg_wdata;
            if (sel_trigger) trigger_reg <= reg_wdata & sdc_pkg::MASK_TRIGGER;
            if (sel_source) source_reg <= reg_wdata & sdc_pkg::MASK_SOURCE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd_en) begin
            rdata_reg <= rdata_next;
        end
    end

    // Control fields
    logic       powerdown_w;
    logic [6:0] code_w;
    assign powerdown_w = pwr_div_reg[sdc_pkg::POS_POWERDOWN];
    assign code_w      = pwr_div_reg[6:0];

    // Stage ratios, lowest stage first
    logic [RW-1:0] ratio_w [NS];
    logic [1:0]    low_code_w;
    logic [1:0]    mid_lo_code_w;
    logic [1:0]    mid_hi_code_w;
    assign low_code_w    = code_w[sdc_pkg::POS_LOW_STAGE +: 2];
    assign mid_lo_code_w = code_w[sdc_pkg::POS_MID_LO +: 2];
    assign mid_hi_code_w = code_w[sdc_pkg::POS_MID_HI +: 2];
    assign ratio_w[0] = sdc_pkg::RATIO_LOW_BASE + RW'(low_code_w);
    assign ratio_w[1] = sdc_pkg::RATIO_TWO << mid_lo_code_w;
    assign ratio_w[2] = sdc_pkg::RATIO_TWO << mid_hi_code_w;
    assign ratio_w[3] = code_w[sdc_pkg::POS_TOP_STAGE] ? sdc_pkg::RATIO_FOUR
                                                       : sdc_pkg::RATIO_TWO;

    // Product of the four stage ratios
    assign total_next = TW'(ratio_w[0]) * TW'(ratio_w[1])
                      * TW'(ratio_w[2]) * TW'(ratio_w[3]);

    // Cascaded stages; the lowest advances every cycle out of power-down, each other on the wrap of the one below
    logic [NS:0]   en_w;
    logic [CW-1:0] count_w [NS];
    assign en_w[0] = ~powerdown_w;

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_stage
            sdc_div_stage u_stage (
                .clk_sys (clk_sys),
                .rst     (rst),
                .restart (powerdown_w),
                .en_in   (en_w[gi]),
                .ratio   (ratio_w[gi]),
                .en_out  (en_w[gi+1]),
                .count   (count_w[gi])
            );
        end
    endgenerate

    // High for the first half of the top stage, giving an even duty cycle
    logic [RW-1:0] top_half_w;
    assign top_half_w      = ratio_w[NS-1] >> 1;
    assign sysref_out_next = ~powerdown_w & ({1'b0, count_w[NS-1]} < top_half_w);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sysref_out_reg <= 1'b0;
            total_reg      <= sdc_pkg::TOTAL_RST;
        end else begin
            sysref_out_reg <= sysref_out_next;
            total_reg      <= total_next;
        end
    end

    assign reg_rdata              = rdata_reg;
    assign sysref_out             = sysref_out_reg;
    assign sysref_active          = ~powerdown_w;
    assign sysref_ratio_total     = total_reg;
    assign bias_sync_cfg          = bias_sync_reg;
    assign pulse_cfg              = pulse_reg;
    assign phase_cfg              = phase_reg;
    assign generation_trigger_bit = trigger_reg[1];
    assign output_trigger_bit     = trigger_reg[0];
    assign source_select_bit      = source_reg[7];

    // Helper logic for period checks
    logic [TW-1:0]                 per_cnt_reg;
    logic [sdc_pkg::STABLE_W-1:0]  stable_reg;
    logic                          out_prev_reg;
    logic                          rise_w;
    logic                          cfg_change_w;
    assign rise_w       = sysref_out_reg & ~out_prev_reg;
    assign cfg_change_w = reg_wr_en & sel_pwr_div;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            per_cnt_reg  <= '0;
            stable_reg   <= '0;
            out_prev_reg <= 1'b0;
        end else begin
            out_prev_reg <= sysref_out_reg;
            per_cnt_reg  <= rise_w ? '0 : per_cnt_reg + TW'(1);
            if (cfg_change_w) begin
                stable_reg <= '0;
            end else if (!(&stable_reg)) begin
                stable_reg <= stable_reg + sdc_pkg::STABLE_W'(1);
            end
        end
    end

    property p_pd_quiet;
        @(posedge clk_sys) disable iff (rst)
        powerdown_w |=> (!sysref_out_reg && count_w[0] == '0 && count_w[NS-1] == '0);
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("output active in power-down");

    property p_restart;
        @(posedge clk_sys) disable iff (rst)
        $fell(powerdown_w) |-> (count_w[0] == '0 && count_w[1] == '0
                               && count_w[2] == '0 && count_w[3] == '0);
    endproperty
    a_restart: assert property (p_restart) else $error("chain not restarted");

    property p_low_ratio;
        @(posedge clk_sys) disable iff (rst)
        (low_code_w == 2'b11) |-> (ratio_w[0] == RW'(5));
    endproperty
    a_low_ratio: assert property (p_low_ratio) else $error("low stage ratio wrong");

    property p_low_wrap;
        @(posedge clk_sys) disable iff (rst)
        (!powerdown_w && low_code_w == 2'b01 && stable_reg > sdc_pkg::STABLE_W'(4))
            |-> (count_w[0] == $past(count_w[0], 3));
    endproperty
    a_low_wrap: assert property (p_low_wrap) else $error("low stage not by three");

    property p_mid_ratio;
        @(posedge clk_sys) disable iff (rst)
        (mid_hi_code_w == 2'b11) |-> (ratio_w[2] == RW'(16));
    endproperty
    a_mid_ratio: assert property (p_mid_ratio) else $error("middle stage ratio wrong");

    property p_top_ratio;
        @(posedge clk_sys) disable iff (rst)
        code_w[sdc_pkg::POS_TOP_STAGE] |-> (ratio_w[3] == RW'(4));
    endproperty
    a_top_ratio: assert property (p_top_ratio) else $error("top stage ratio wrong");

    property p_total;
        @(posedge clk_sys) disable iff (rst)
        !cfg_change_w |=> (total_reg == $past(total_next));
    endproperty
    a_total: assert property (p_total) else $error("total ratio mismatch");

    property p_period;
        @(posedge clk_sys) disable iff (rst)
        (rise_w && !powerdown_w && stable_reg > {2'b00, total_reg, 1'b0})
            |-> (per_cnt_reg + TW'(1) == total_reg);
    endproperty
    a_period: assert property (p_period) else $error("output period wrong");

    c_rise: cover property (@(posedge clk_sys) disable iff (rst) rise_w);
    c_powerup: cover property (@(posedge clk_sys) disable iff (rst) $fell(powerdown_w));
    c_period: cover property (@(posedge clk_sys) disable iff (rst)
        rise_w && stable_reg > {2'b00, total_reg, 1'b0});
endmodule

// ===== test_sysref_divider_control.sv
module test_sysref_divider_control;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys            = 1'b0;
    logic        rst                = 1'b1;
    logic        reg_wr_en          = 1'b0;
    logic        reg_rd_en          = 1'b0;
    logic [6:0]  reg_addr           = 7'h00;
    logic [7:0]  reg_wdata          = 8'h00;
    logic [7:0]  reg_rdata;
    logic        sysref_out;
    logic        sysref_active;
    logic [12:0] sysref_ratio_total;
    logic [7:0]  bias_sync_cfg;
    logic [7:0]  pulse_cfg;
    logic [7:0]  phase_cfg;
    logic        generation_trigger_bit;
    logic        output_trigger_bit;
    logic        source_select_bit;
    logic        rd_d               = 1'b0;
    logic        w1                 = 1'b0;
    logic        w2                 = 1'b0;
    logic [15:0] q_rd[$];
    logic [15:0] q_ratio[$];
    int          n_errors           = 0;
    int          compares           = 0;
    int          seed               = 28897;
    logic [7:0]  v[5];
    logic [6:0]  pcodes[6]          = '{7'h00, 7'h03, 7'h05, 7'h0e, 7'h07, 7'h7d};
    logic [12:0] r;
    int          n;

    sdc_sysref_divider DUT (
        .clk_sys(clk_sys), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sysref_out(sysref_out), .sysref_active(sysref_active),
        .sysref_ratio_total(sysref_ratio_total), .bias_sync_cfg(bias_sync_cfg),
        .pulse_cfg(pulse_cfg), .phase_cfg(phase_cfg),
        .generation_trigger_bit(generation_trigger_bit),
        .output_trigger_bit(output_trigger_bit), .source_select_bit(source_select_bit)
    );

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic logic [12:0] ratio_of(input logic [6:0] c);
        ratio_of = (c[6] ? 13'h0004 : 13'h0002) * (13'h0002 << c[5:4])
                 * (13'h0002 << c[3:2]) * (13'h0002 + 13'(c[1:0]));
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic rd, input logic [6:0] a,
                       input logic [7:0] d, input logic [7:0] e);
        @(negedge clk_sys);
        reg_wr_en = w;
        reg_rd_en = rd;
        reg_addr = a;
        reg_wdata = d;
        if (rd) q_rd.push_back({8'h00, e});
        if (w && a == sdc_pkg::ADDR_PWR_DIV) q_ratio.push_back({3'b000, ratio_of(d[6:0])});
    endtask

    task automatic idle(input int k);
        repeat (k) begin
            @(negedge clk_sys);
            reg_wr_en = 1'b0;
            reg_rd_en = 1'b0;
        end
    endtask

    task automatic run_len(input logic lv, output int k);
        k = 0;
        while (sysref_out === lv && k < 6000) begin
            idle(1);
            k++;
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Result watcher: read data one edge late, ratio two edges after a write
    always @(posedge clk_sys) begin
        rd_d <= reg_rd_en & ~rst;
        w1 <= reg_wr_en & ~rst & (reg_addr == sdc_pkg::ADDR_PWR_DIV);
        w2 <= w1;
    end

    always @(negedge clk_sys) begin
        if (rd_d) chk("reg_rdata", q_rd.size() > 0 ? q_rd.pop_front() : 16'hffff, 16'(reg_rdata));
        if (w2) chk("ratio_total", q_ratio.size() > 0 ? q_ratio.pop_front() : 16'hffff,
                    16'(sysref_ratio_total));
    end

    initial begin
        #(60000 * 100);
        n_errors++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        idle(2);
        chk("ratio_reset", 16'h0500, 16'(sysref_ratio_total));
        bus(0, 1, sdc_pkg::ADDR_PWR_DIV, 8'h00, 8'h2f);
        bus(0, 1, sdc_pkg::ADDR_BIAS_SYNC, 8'h00, 8'h00);
        bus(0, 1, sdc_pkg::ADDR_TRIGGER, 8'h00, 8'h00);
        bus(0, 1, sdc_pkg::ADDR_SOURCE, 8'h00, 8'h00);
        idle(1);
        $display("test reset_values done");
        foreach (v[i]) v[i] = 8'($random(seed));
        bus(1, 0, sdc_pkg::ADDR_BIAS_SYNC, v[0], 8'h00);
        bus(1, 0, sdc_pkg::ADDR_PULSE, v[1], 8'h00);
        bus(1, 0, sdc_pkg::ADDR_PHASE, v[2], 8'h00);
        bus(1, 0, sdc_pkg::ADDR_TRIGGER, v[3], 8'h00);
        bus(1, 0, sdc_pkg::ADDR_SOURCE, v[4], 8'h00);
        bus(1, 0, 7'h20, 8'hff, 8'h00);
        bus(0, 1, sdc_pkg::ADDR_PULSE, 8'h00, v[1]);
        bus(0, 1, sdc_pkg::ADDR_PHASE, 8'h00, v[2]);
        bus(0, 1, sdc_pkg::ADDR_TRIGGER, 8'h00, v[3] & 8'h03);
        bus(0, 1, sdc_pkg::ADDR_SOURCE, 8'h00, v[4] & 8'h80);
        bus(0, 1, 7'h20, 8'h00, 8'h00);
        bus(1, 1, sdc_pkg::ADDR_BIAS_SYNC, ~v[0], v[0]);
        idle(1);
        chk("bias_sync_cfg", {8'h00, ~v[0]}, 16'(bias_sync_cfg));
        chk("pulse_cfg", {8'h00, v[1]}, 16'(pulse_cfg));
        chk("phase_cfg", {8'h00, v[2]}, 16'(phase_cfg));
        chk("trig_bits", 16'(v[3][1:0]), 16'({generation_trigger_bit, output_trigger_bit}));
        chk("source_sel", 16'(v[4][7]), 16'(source_select_bit));
        $display("test register_access done");
        for (int c = 0; c < 128; c++) bus(1, 0, sdc_pkg::ADDR_PWR_DIV, 8'(c), 8'h00);
        idle(3);
        $display("test ratio_all_codes done");
        foreach (pcodes[i]) begin
            r = ratio_of(pcodes[i]);
            bus(1, 0, sdc_pkg::ADDR_PWR_DIV, {1'b0, pcodes[i]}, 8'h00);
            idle(int'(r) + 2);
            run_len(1'b1, n);
            run_len(1'b0, n);
            run_len(1'b1, n);
            chk("high_len", 16'(r >> 1), 16'(n));
            run_len(1'b0, n);
            chk("low_len", 16'(r >> 1), 16'(n));
        end
        $display("test output_period done");
        repeat (2) begin
            bus(1, 0, sdc_pkg::ADDR_PWR_DIV, 8'h8e, 8'h00);
            idle(1);
            chk("active_off", 16'h0000, 16'(sysref_active));
            repeat (40) begin
                idle(1);
                chk("out_off", 16'h0000, 16'(sysref_out));
            end
            bus(1, 0, sdc_pkg::ADDR_PWR_DIV, 8'h00, 8'h00);
            idle(1);
            chk("active_on", 16'h0001, 16'(sysref_active));
            chk("out_c1", 16'h0000, 16'(sysref_out));
            idle(1);
            chk("out_c2", 16'h0001, 16'(sysref_out));
            run_len(1'b1, n);
            chk("first_high", 16'h0008, 16'(n));
        end
        $display("test powerdown_restart done");
        conclude();
    end
endmodule
